/* logic/adcsq_pkg.sv */
// Purpose: Shared constants, types and decode functions for the converter sequencer control.
// Assumes: One system clock; the sample rate is one eighth of it.
// Notes: Offsets are special-function register addresses on the byte-wide register port.
// Function
// - Sequence reference chosen by two-bit field.
// - Conversion lasts decimation plus sixteen sample periods.
// - Fixed divide-by-eight gives the sample clock.
// - Interrupt only on single conversion completion.
// - DMA trigger only on sequence conversion completion.
// - Per-channel DMA pulse for channels zero to seven.
// - Any-channel DMA pulse for every sequence result.
// - Low result holds bits five..zero, low zeros.
// - High result holds bits thirteen..six, reset zero.
// - Done flag set at end, cleared reading high.
// - Unread result keeps done flag set, no overrun.
// - Go bit starts sequence if manual and idle.
// - Trigger select: pin, continuous, timer, go bit.
// - Bits three..two forwarded to random generator.
// - Decimation codes select 64, 128, 256, 512.
// - Single conversion queued behind a running sequence.
// - Sequence channels built from the end field.
// - Results two's complement, left aligned.
package adcsq_pkg;

	localparam logic [7:0] ADDR_CTRL_ONE = 8'hb4;
	localparam logic [7:0] ADDR_SEQ_CFG = 8'hb5;
	localparam logic [7:0] ADDR_SINGLE_CFG = 8'hb6;
	localparam logic [7:0] ADDR_RES_LOW = 8'hba;
	localparam logic [7:0] ADDR_RES_HIGH = 8'hbb;

	localparam int CTRL_EOC_BIT = 7;
	localparam int CTRL_ST_BIT = 6;
	localparam int CTRL_TRIGGER_SOURCE_SELECT_LSB = 4;
	localparam int CTRL_RNG_LSB = 2;
	localparam int CTRL_RSV_LSB = 0;
	localparam int CFG_REF_LSB = 6;
	localparam int CFG_DIV_LSB = 4;
	localparam int CFG_CH_LSB = 0;
	localparam int RES_LOW_LSB = 2;
	localparam int RES_W = 14;
	localparam int RES_SPLIT = 6;

	localparam logic [1:0] TRIGGER_SOURCE_SELECT_RST = 2'h3;
	localparam logic [1:0] RNG_RST = 2'h0;
	localparam logic [1:0] RSV_RST = 2'h3;
	localparam logic [1:0] SEQ_REFERENCE_CHOICE_RST = 2'h0;
	localparam logic [1:0] SEQ_DECIMATION_CHOICE_RST = 2'h1;
	localparam logic [3:0] SCH_RST = 4'h0;
	localparam logic [7:0] SINGLE_CFG_RST = 8'h00;
	localparam logic [13:0] RES_RST = 14'h0000;

	localparam logic [1:0] TRIG_PIN = 2'h0;
	localparam logic [1:0] TRIG_FULL = 2'h1;
	localparam logic [1:0] TRIG_TIMER = 2'h2;
	localparam logic [1:0] TRIG_MANUAL = 2'h3;

	localparam logic [3:0] CH_DIFF_FIRST = 4'h8;
	localparam logic [3:0] CH_SINGLE_ONLY = 4'hc;
	localparam int DMA_CH_COUNT = 8;

	// A 32 MHz system clock period, and the 0.25 us sample period.
	localparam int SYS_CLK_PERIOD_PS = 31250;
	localparam int SAMPLE_PERIOD_PS = 250000;
	localparam int SAMPLE_DIV = SAMPLE_PERIOD_PS / SYS_CLK_PERIOD_PS;
	localparam int DIV_W = 3;
	localparam int CONV_EXTRA_PERIODS = 16;
	localparam int DECIM_BASE = 64;
	localparam int CNT_W = 10;

	typedef enum logic [2:0] {
		CS_IDLE = 3'b001,
		CS_SINGLE = 3'b010,
		CS_SEQ = 3'b100
	} adcsq_conv_state_t;

	// Sample periods for one conversion: 64, 128, 256 or 512 plus sixteen.
	function automatic logic [CNT_W-1:0] conv_periods(input logic [1:0] code);
		conv_periods = (CNT_W'(DECIM_BASE) << code) + CNT_W'(CONV_EXTRA_PERIODS);
	endfunction

	function automatic logic [3:0] seq_first(input logic [3:0] last);
		if (last < CH_DIFF_FIRST)
			seq_first = 4'h0;
		else if (last < CH_SINGLE_ONLY)
			seq_first = CH_DIFF_FIRST;
		else
			seq_first = last;
	endfunction

	function automatic logic [3:0] seq_after(input logic [3:0] last);
		seq_after = (last < CH_SINGLE_ONLY) ? last + 4'h1 : last;
	endfunction

endpackage

/* logic/adcsq_conv_timer.sv */
// Purpose: Sample clock divider and conversion length counter.
// Assumes: Start arrives only while the timer is not busy.
// Notes: The divider runs free, so the first period may be short by up to seven clocks.
module adcsq_conv_timer (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic start_i,
	input wire logic [1:0] decim_i,
	output logic busy_o,
	output logic done_o
);

	logic [adcsq_pkg::DIV_W-1:0] div_r;
	logic sample_en_r;
	logic [adcsq_pkg::CNT_W-1:0] cnt_r;
	logic busy_r;
	logic done_r;
	wire div_wrap = (div_r == adcsq_pkg::DIV_W'(adcsq_pkg::SAMPLE_DIV - 1));
	wire last_period = busy_r && sample_en_r && (cnt_r == '0);

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			div_r <= '0;
			sample_en_r <= 1'b0;
		end else begin
			div_r <= div_wrap ? '0 : div_r + adcsq_pkg::DIV_W'(1);
			sample_en_r <= div_wrap;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= last_period;
			if (start_i && !busy_r) begin
				busy_r <= 1'b1;
				cnt_r <= adcsq_pkg::conv_periods(decim_i) - adcsq_pkg::CNT_W'(1);
			end else if (last_period) begin
				busy_r <= 1'b0;
			end else if (busy_r && sample_en_r) begin
				cnt_r <= cnt_r - adcsq_pkg::CNT_W'(1);
			end
		end
	end

	assign busy_o = busy_r;
	assign done_o = done_r;

endmodule

/* logic/adcsq_ctrl.sv */
// Purpose: Register file, trigger selection and sequencing around the converter core.
// Assumes: The core presents a stable, left-aligned result on conv_data_i while done is reported.
// Notes: Read data appears one clock after the read strobe; side effects act at the strobe.
module adcsq_ctrl (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic external_trigger_pin_i,
	input wire logic timer_compare_i,
	input wire logic [13:0] conv_data_i,
	output logic [7:0] sfr_rdata_o,
	output logic conv_start_o,
	output logic [3:0] conv_channel_o,
	output logic [1:0] conv_ref_o,
	output logic [1:0] conv_decim_o,
	output logic irq_o,
	output logic any_channel_dma_request_o,
	output logic [7:0] per_channel_dma_request_o,
	output logic [1:0] rng_ctrl_o
);

	// Control register one.
	logic eoc_r;
	logic manual_go_bit_r;
	logic [1:0] trigger_source_select_r;
	logic [1:0] rng_ctrl_r;
	logic [1:0] rsv_r;
	// Sequence configuration.
	logic [1:0] seq_reference_choice_r;
	logic [1:0] seq_decimation_choice_r;
	logic [3:0] seq_last_r;
	logic [3:0] sequence_end_field_r;
	// Single conversion configuration.
	logic [7:0] single_conversion_config_r;
	logic single_pend_r;
	// Sequencer.
	adcsq_pkg::adcsq_conv_state_t cs_r;
	adcsq_pkg::adcsq_conv_state_t cs_nxt;
	logic seq_active_r;
	logic seq_need_r;
	logic seq_req_r;
	logic [13:0] res_r;
	// Converter and event outputs.
	logic launch_r;
	logic [3:0] conv_channel_r;
	logic [1:0] conv_ref_r;
	logic [1:0] conv_decim_r;
	logic irq_r;
	logic any_dma_r;
	logic [7:0] ch_dma_r;
	logic [7:0] rdata_r;
	logic [2:0] pin_sync_r;
	logic pin_lvl_r;

	logic tmr_busy;
	logic tmr_done;

	adcsq_conv_timer u_timer (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.start_i(launch_r),
		.decim_i(conv_decim_r),
		.busy_o(tmr_busy),
		.done_o(tmr_done)
	);

	// Register port decode.
	wire wr_ctrl = sfr_wr_i && (sfr_addr_i == adcsq_pkg::ADDR_CTRL_ONE);
	wire wr_seq = sfr_wr_i && (sfr_addr_i == adcsq_pkg::ADDR_SEQ_CFG);
	wire wr_single = sfr_wr_i && (sfr_addr_i == adcsq_pkg::ADDR_SINGLE_CFG);
	wire rd_high = sfr_rd_i && (sfr_addr_i == adcsq_pkg::ADDR_RES_HIGH);

	wire [1:0] wr_trigger_source_select = sfr_wdata_i[adcsq_pkg::CTRL_TRIGGER_SOURCE_SELECT_LSB +: 2];
	wire wr_go = wr_ctrl && sfr_wdata_i[adcsq_pkg::CTRL_ST_BIT] && (wr_trigger_source_select == adcsq_pkg::TRIG_MANUAL)
		&& !seq_active_r;

	// The first stage is read only by the second. A level counts once stages two and three agree,
	// so a glitch shorter than two clocks never starts a sequence.
	wire pin_agree = (pin_sync_r[1] == pin_sync_r[2]);
	wire pin_rise = pin_agree && pin_sync_r[2] && !pin_lvl_r;

	logic trig_sel;
	always_comb begin
		unique case (trigger_source_select_r)
			adcsq_pkg::TRIG_PIN: trig_sel = pin_rise;
			adcsq_pkg::TRIG_FULL: trig_sel = 1'b1;
			adcsq_pkg::TRIG_TIMER: trig_sel = timer_compare_i;
			adcsq_pkg::TRIG_MANUAL: trig_sel = manual_go_bit_r;
		endcase
	end

	// A trigger is accepted only between sequences; it waits there while a single runs.
	wire trig_take = trig_sel && !seq_active_r;
	wire idle = (cs_r == adcsq_pkg::CS_IDLE) && !tmr_busy;
	wire launch_single = idle && single_pend_r && !seq_active_r;
	wire launch_seq = idle && seq_active_r && seq_need_r;
	wire seq_begin = idle && seq_req_r && !seq_active_r && !single_pend_r;

	wire done_single = tmr_done && (cs_r == adcsq_pkg::CS_SINGLE);
	wire done_seq = tmr_done && (cs_r == adcsq_pkg::CS_SEQ);
	wire seq_last_done = done_seq && (sequence_end_field_r == seq_last_r);

	always_comb begin
		cs_nxt = cs_r;
		unique case (cs_r)
			adcsq_pkg::CS_IDLE: begin
				if (launch_single)
					cs_nxt = adcsq_pkg::CS_SINGLE;
				else if (launch_seq)
					cs_nxt = adcsq_pkg::CS_SEQ;
			end
			adcsq_pkg::CS_SINGLE: begin
				if (tmr_done)
					cs_nxt = adcsq_pkg::CS_IDLE;
			end
			adcsq_pkg::CS_SEQ: begin
				if (tmr_done)
					cs_nxt = adcsq_pkg::CS_IDLE;
			end
			default: cs_nxt = adcsq_pkg::CS_IDLE;
		endcase
	end

	// Read multiplexer; unmapped addresses read as zero.
	wire [7:0] rd_ctrl = {eoc_r, manual_go_bit_r, trigger_source_select_r, rng_ctrl_r, rsv_r};
	wire [7:0] rd_seq = {seq_reference_choice_r, seq_decimation_choice_r, sequence_end_field_r};
	wire [7:0] rd_low = {res_r[adcsq_pkg::RES_SPLIT-1:0], 2'h0};
	wire [7:0] rd_hi = res_r[adcsq_pkg::RES_W-1:adcsq_pkg::RES_SPLIT];

	logic [7:0] rdata_nxt;
	always_comb begin
		unique case (sfr_addr_i)
			adcsq_pkg::ADDR_CTRL_ONE: rdata_nxt = rd_ctrl;
			adcsq_pkg::ADDR_SEQ_CFG: rdata_nxt = rd_seq;
			adcsq_pkg::ADDR_SINGLE_CFG: rdata_nxt = single_conversion_config_r;
			adcsq_pkg::ADDR_RES_LOW: rdata_nxt = rd_low;
			adcsq_pkg::ADDR_RES_HIGH: rdata_nxt = rd_hi;
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i)
			rdata_r <= 8'h00;
		else if (sfr_rd_i)
			rdata_r <= rdata_nxt;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			pin_sync_r <= 3'h0;
			pin_lvl_r <= 1'b0;
		end else begin
			pin_sync_r <= {pin_sync_r[1:0], external_trigger_pin_i};
			if (pin_agree)
				pin_lvl_r <= pin_sync_r[2];
		end
	end

	// Control register one. The reserved pair is stored as written.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			trigger_source_select_r <= adcsq_pkg::TRIGGER_SOURCE_SELECT_RST;
			rng_ctrl_r <= adcsq_pkg::RNG_RST;
			rsv_r <= adcsq_pkg::RSV_RST;
		end else if (wr_ctrl) begin
			trigger_source_select_r <= wr_trigger_source_select;
			rng_ctrl_r <= sfr_wdata_i[adcsq_pkg::CTRL_RNG_LSB +: 2];
			rsv_r <= sfr_wdata_i[adcsq_pkg::CTRL_RSV_LSB +: 2];
		end
	end

	// Done flag: a new result while the old is unread keeps it high, and set beats clear.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i)
			eoc_r <= 1'b0;
		else if (tmr_done)
			eoc_r <= 1'b1;
		else if (rd_high)
			eoc_r <= 1'b0;
	end

	// Go bit reads one from acceptance until its sequence completes.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i)
			manual_go_bit_r <= 1'b0;
		else if (seq_last_done)
			manual_go_bit_r <= 1'b0;
		else if (wr_go)
			manual_go_bit_r <= 1'b1;
	end

	// Sequence configuration; the channel field reads back the channel in progress.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			seq_reference_choice_r <= adcsq_pkg::SEQ_REFERENCE_CHOICE_RST;
			seq_decimation_choice_r <= adcsq_pkg::SEQ_DECIMATION_CHOICE_RST;
			seq_last_r <= adcsq_pkg::SCH_RST;
		end else if (wr_seq) begin
			seq_reference_choice_r <= sfr_wdata_i[adcsq_pkg::CFG_REF_LSB +: 2];
			seq_decimation_choice_r <= sfr_wdata_i[adcsq_pkg::CFG_DIV_LSB +: 2];
			seq_last_r <= sfr_wdata_i[adcsq_pkg::CFG_CH_LSB +: 4];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			seq_active_r <= 1'b0;
			seq_need_r <= 1'b0;
			seq_req_r <= 1'b0;
			sequence_end_field_r <= adcsq_pkg::SCH_RST;
		end else begin
			if (seq_begin)
				seq_req_r <= 1'b0;
			else if (trig_take)
				seq_req_r <= 1'b1;
			if (seq_begin) begin
				seq_active_r <= 1'b1;
				seq_need_r <= 1'b1;
				sequence_end_field_r <= adcsq_pkg::seq_first(seq_last_r);
			end else if (seq_last_done) begin
				seq_active_r <= 1'b0;
				sequence_end_field_r <= adcsq_pkg::seq_after(seq_last_r);
			end else if (done_seq) begin
				seq_need_r <= 1'b1;
				sequence_end_field_r <= sequence_end_field_r + 4'h1;
			end else if (launch_seq) begin
				seq_need_r <= 1'b0;
			end else if (wr_seq && !seq_active_r) begin
				sequence_end_field_r <= sfr_wdata_i[adcsq_pkg::CFG_CH_LSB +: 4];
			end
		end
	end

	// Single conversion: writing the register queues it; it runs once no sequence holds the core.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			single_conversion_config_r <= adcsq_pkg::SINGLE_CFG_RST;
			single_pend_r <= 1'b0;
		end else if (wr_single) begin
			single_conversion_config_r <= sfr_wdata_i;
			single_pend_r <= 1'b1;
		end else if (launch_single) begin
			single_pend_r <= 1'b0;
		end
	end

	// Launch towards the core and the conversion timer.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			cs_r <= adcsq_pkg::CS_IDLE;
			launch_r <= 1'b0;
			conv_channel_r <= adcsq_pkg::SCH_RST;
			conv_ref_r <= adcsq_pkg::SEQ_REFERENCE_CHOICE_RST;
			conv_decim_r <= adcsq_pkg::SEQ_DECIMATION_CHOICE_RST;
		end else begin
			cs_r <= cs_nxt;
			launch_r <= launch_single || launch_seq;
			if (launch_single) begin
				conv_channel_r <= single_conversion_config_r[adcsq_pkg::CFG_CH_LSB +: 4];
				conv_ref_r <= single_conversion_config_r[adcsq_pkg::CFG_REF_LSB +: 2];
				conv_decim_r <= single_conversion_config_r[adcsq_pkg::CFG_DIV_LSB +: 2];
			end else if (launch_seq) begin
				conv_channel_r <= sequence_end_field_r;
				conv_ref_r <= seq_reference_choice_r;
				conv_decim_r <= seq_decimation_choice_r;
			end
		end
	end

	// Result is taken as the core delivers it, already two's complement and left aligned.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i)
			res_r <= adcsq_pkg::RES_RST;
		else if (tmr_done)
			res_r <= conv_data_i;
	end

	// Completion events; each is one clock wide.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			irq_r <= 1'b0;
			any_dma_r <= 1'b0;
		end else begin
			irq_r <= done_single;
			any_dma_r <= done_seq;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < adcsq_pkg::DMA_CH_COUNT; gi++) begin : g_ch_dma
			always_ff @(posedge core_clk_i) begin
				if (!rst_b_i)
					ch_dma_r[gi] <= 1'b0;
				else
					ch_dma_r[gi] <= done_seq && (sequence_end_field_r == 4'(gi));
			end
		end
	endgenerate

	assign sfr_rdata_o = rdata_r;
	assign conv_start_o = launch_r;
	assign conv_channel_o = conv_channel_r;
	assign conv_ref_o = conv_ref_r;
	assign conv_decim_o = conv_decim_r;
	assign irq_o = irq_r;
	assign any_channel_dma_request_o = any_dma_r;
	assign per_channel_dma_request_o = ch_dma_r;
	assign rng_ctrl_o = rng_ctrl_r;

endmodule

/* sim/adcsq_props.sv */
// Purpose: Port-level assertions for the sequencer control.
// Assumes: One clock domain; bound to adcsq_ctrl.
// Notes: The length window is wide because the sample divider runs free.
module adcsq_props (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic conv_start_o,
	input wire logic [3:0] conv_channel_o,
	input wire logic [1:0] conv_decim_o,
	input wire logic irq_o,
	input wire logic any_channel_dma_request_o,
	input wire logic [7:0] per_channel_dma_request_o,
	input wire logic [1:0] rng_ctrl_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [12:0] age_r;
	int nom;
	logic fin;
	assign nom = 8 * ((64 << conv_decim_o) + 16);
	assign fin = irq_o | any_channel_dma_request_o;
	default clocking dclk @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i || conv_start_o)
			age_r <= 13'h0000;
		else if (age_r != 13'h1fff)
			age_r <= age_r + 13'h0001;
	end
	a_len_window: assert property (fin |-> age_r >= nom - 10 && age_r <= nom + 10)
		else $error("conversion length out of window");
	a_irq_only: assert property (irq_o |-> !any_channel_dma_request_o && per_channel_dma_request_o == 8'h00)
		else $error("dma with single result");
	a_irq_pulse: assert property (irq_o |=> !irq_o)
		else $error("irq longer than one cycle");
	a_any_pulse: assert property (any_channel_dma_request_o |=> !any_channel_dma_request_o)
		else $error("dma longer than one cycle");
	a_chan_match: assert property (any_channel_dma_request_o && conv_channel_o < 4'h8
		|-> per_channel_dma_request_o == 8'h01 << conv_channel_o)
		else $error("wrong channel dma");
	a_chan_none: assert property (any_channel_dma_request_o && conv_channel_o >= 4'h8 |-> !(|per_channel_dma_request_o))
		else $error("channel dma for upper channel");
	a_chan_cause: assert property (|per_channel_dma_request_o |-> any_channel_dma_request_o)
		else $error("channel dma without common dma");
	a_start_gap: assert property (conv_start_o |=> !conv_start_o [*8])
		else $error("launch too soon");
	a_reset_vals: assert property ($rose(rst_b_i) |-> rng_ctrl_o == 2'h0 && conv_decim_o == 2'h1 && !fin)
		else $error("bad output after reset");
	cover property (irq_o);
	cover property (per_channel_dma_request_o[3]);
	cover property (any_channel_dma_request_o && conv_channel_o == 4'hc);
endmodule

bind adcsq_ctrl adcsq_props adcsq_props_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
	.conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o), .conv_decim_o(conv_decim_o),
	.irq_o(irq_o), .any_channel_dma_request_o(any_channel_dma_request_o),
	.per_channel_dma_request_o(per_channel_dma_request_o), .rng_ctrl_o(rng_ctrl_o));

/* sim/adcsq_core_model.sv */
// Purpose: Behavioural stand-in for the analog modulator core.
// Assumes: One conversion at a time.
// Notes: A result is held from launch to the next launch, so it is stable at conversion end.
module adcsq_core_model (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic conv_start_i,
	input wire logic [3:0] conv_channel_i,
	output logic [13:0] conv_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge core_clk_i) begin
		if (!rst_b_i)
			conv_data_o <= 14'h2aaa;
		else if (conv_start_i)
			conv_data_o <= {conv_channel_i, 10'($urandom)};
	end
endmodule

/* sim/adcsq_ctrl_test.sv */
// Purpose: Self-checking bench for the sequencer control.
// Assumes: Only cycle counts matter, so the faster bench clock is harmless.
// Notes: Sequences use the shortest decimation to keep the run brief.
module adcsq_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic pin = 1'b0;
	logic tmr = 1'b0;
	logic [13:0] cdata;
	logic [7:0] rdata;
	logic start;
	logic [3:0] ch;
	logic [1:0] cref;
	logic [1:0] cdec;
	logic irq;
	logic dma;
	logic [7:0] pdma;
	logic [1:0] rng;
	logic [13:0] last;
	logic [7:0] d;
	logic [1:0] r;
	logic ev_irq;
	int error_cnt = 0;
	int checks = 0;
	int q[$];

	always #2 core_clk_i = ~core_clk_i;

	adcsq_ctrl adcsq_ctrl_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(addr),
		.sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .external_trigger_pin_i(pin),
		.timer_compare_i(tmr), .conv_data_i(cdata), .sfr_rdata_o(rdata), .conv_start_o(start),
		.conv_channel_o(ch), .conv_ref_o(cref), .conv_decim_o(cdec), .irq_o(irq),
		.any_channel_dma_request_o(dma), .per_channel_dma_request_o(pdma), .rng_ctrl_o(rng));
	adcsq_core_model adcsq_core_model_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
		.conv_start_i(start), .conv_channel_i(ch), .conv_data_o(cdata));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk_i);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge core_clk_i);
		wr <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk_i);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask

	// Waits for the next result pulse; a missing one counts as a mismatch.
	task automatic wait_ev();
		int n;
		n = 0;
		do begin
			@(posedge core_clk_i);
			#1;
			n++;
		end while (irq !== 1'b1 && dma !== 1'b1 && n < 6000);
		if (n >= 6000)
			chk(8'h00, 8'h01);
		ev_irq = irq;
		last = cdata;
	endtask

	task automatic chk_res();
		rc(8'hba, {last[5:0], 2'b00});
		rc(8'hbb, last[13:6]);
	endtask

	task automatic run_seq(input logic [1:0] trig, input logic [3:0] lc, input bit qs);
		logic [1:0] seq_reference_choice;
		seq_reference_choice = 2'($urandom);
		q.delete();
		if (lc < 8)
			for (int c = 0; c <= lc; c++) q.push_back(c);
		else if (lc < 12)
			for (int c = 8; c <= lc; c++) q.push_back(c);
		else
			q.push_back(lc);
		if (trig == 2'h1)
			q.push_back(lc);
		wr_reg(8'hb5, {seq_reference_choice, 2'h0, lc});
		wr_reg(8'hb4, {2'b01, trig, r, 2'b11});
		if (trig != 2'h1)
			rc(8'hb4, {1'b0, trig == 2'h3, trig, r, 2'b11});
		if (qs)
			wr_reg(8'hb6, 8'h45);
		// The timer event is one clock wide; the pin must stand long enough for the filter.
		@(posedge core_clk_i);
		pin <= trig == 2'h0;
		tmr <= trig == 2'h2;
		@(posedge core_clk_i);
		tmr <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		pin <= 1'b0;
		while (q.size() > 0) begin
			wait_ev();
			chk({ev_irq, cref, 1'b0, ch}, {1'b0, seq_reference_choice, 1'b0, 4'(q[0])});
			chk(pdma, q[0] < 8 ? 8'h01 << q[0] : 8'h00);
			void'(q.pop_front());
		end
		if (qs) begin
			wait_ev();
			chk({ev_irq, cref, 1'b0, ch}, 8'ha5);
		end
		if (trig != 2'h1) begin
			rc(8'hb5, {seq_reference_choice, 2'h0, lc < 12 ? lc + 4'h1 : lc});
			rc(8'hb4, {2'b10, trig, r, 2'b11});
			chk_res();
		end
	endtask

	task automatic end_sim();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		void'($urandom(32'h6312));
		r = 2'($urandom);
		repeat (12) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		rc(8'hb4, 8'h33);
		rc(8'hb5, 8'h10);
		rc(8'hbb, 8'h00);
		rc(8'hba, 8'h00);
		rc(8'hb7, 8'h00);
		chk({4'h0, rng, cdec}, 8'h01);
		wr_reg(8'hb4, {4'h3, r, 2'b11});
		rc(8'hb4, {4'h3, r, 2'b11});
		chk({6'h00, rng}, {6'h00, r});
		// Each single uses a new reference and decimation code, so all four of each are seen.
		for (int i = 0; i < 4; i++) begin
			d = {i[1:0], i[1:0], 4'($urandom)};
			wr_reg(8'hb6, d);
			wait_ev();
			chk({ev_irq, 7'h00}, 8'h80);
			chk({cref, cdec, ch}, d);
			rc(8'hb4, {2'b10, 2'b11, r, 2'b11});
			if (i[0]) begin
				wr_reg(8'hbb, 8'hff);
				chk_res();
				rc(8'hb4, {2'b00, 2'b11, r, 2'b11});
			end
		end
		run_seq(2'h3, 4'h3, 1'b1);
		run_seq(2'h2, 4'h9, 1'b0);
		run_seq(2'h0, 4'hc, 1'b0);
		run_seq(2'h1, 4'hc, 1'b0);
		end_sim();
	end

	initial begin
		#160000;
		error_cnt++;
		end_sim();
	end
endmodule
